// ---- src/sfcr_pkg.sv ----
// Package: constants and types for the serial flash continuous-read front end
// Function
// [RQ1] Opcode E8h: three address bytes, four dummy bytes, then data out.
// [RQ2] Opcode 1Bh: three address bytes, two dummy bytes, then data out.
// [RQ3] Opcode 0Bh: three address bytes, one dummy byte, then data out.
// [RQ4] Opcode 03h: three address bytes, no dummy bytes, data follows at once.
// [RQ5] 528-byte pages: 23-bit address, 13 page bits over 10 byte bits.
// [RQ6] 512-byte pages: 22-bit address, 13 page bits over 9 byte bits.
// [RQ7] Internal read address counter loads start address and advances per byte.
// [RQ8] After dummies, each further serial clock shifts out the next data bit.
// [RQ9] Host holds chip select low through the whole command and read-out.
// [RQ10] Past a page's last byte, reading continues at next page without gap.
// [RQ11] After the array's last byte, reading wraps to page zero without gap.
// [RQ12] Chip select rising ends the read and floats the serial output.
// [RQ13] Continuous reads take array data directly and leave SRAM buffers alone.
// [RQ14] Hosts should prefer the newer opcodes over the legacy four-dummy read.
// [RQ15] Serial clock may idle low or high (SPI mode 0 or 3).
// [RQ16] Opcode, address and data travel most significant bit first.
// [RQ17] A command starts at chip select falling; first eight bits are opcode.
// [RQ18] Dummy byte values and unused high address bits are ignored.
// [RQ19] Page size is a static input choosing address split and page length.
`default_nettype none
package sfcr_pkg;
  localparam logic [7:0]  OP_LEGACY   = 8'hE8;
  localparam logic [7:0]  OP_FASTEST  = 8'h1B;
  localparam logic [7:0]  OP_FAST     = 8'h0B;
  localparam logic [7:0]  OP_SLOW     = 8'h03;
  localparam logic [2:0]  DUMMY_LEGACY  = 3'h4;
  localparam logic [2:0]  DUMMY_FASTEST = 3'h2;
  localparam logic [2:0]  DUMMY_FAST    = 3'h1;
  localparam logic [2:0]  DUMMY_SLOW    = 3'h0;
  localparam int          ADDR_W      = 23;
  localparam int          PAGE_W      = 13;
  localparam logic [9:0]  PAGE_LAST_STD = 10'h20F;
  localparam logic [9:0]  PAGE_LAST_BIN = 10'h1FF;
  localparam logic [12:0] PAGE_LAST_IDX = 13'h1FFF;
  localparam int          FIFO_DEPTH  = 8;
  localparam int          FIFO_AW     = 3;
  localparam logic [2:0]  BIT_RESET   = 3'h0;
  // Array fetch address driven from core to the array
  typedef struct packed {
    logic [PAGE_W-1:0] page;
    logic [9:0]        offs;
  } sfcr_addr_s;
endpackage : sfcr_pkg
`default_nettype wire

// ---- src/sfcr_sync.sv ----
// Two-flop synchroniser for a level
`default_nettype none
module sfcr_sync (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic din,
  output logic      dout
);
  logic meta_r;
  // First stage read only by the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule : sfcr_sync
`default_nettype wire

// ---- src/sfcr_fifo.sv ----
// Dual-clock FIFO with gray pointers
`default_nettype none
module sfcr_fifo #(
  parameter int W  = 8,
  parameter int D  = 8,
  parameter int AW = 3
) (
  input  wire logic         wclk,
  input  wire logic         wrst_b,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  input  wire logic         rclk,
  input  wire logic         rrst_b,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  logic [W-1:0] mem [D];
  logic [AW:0]  wBin_r, wGray_r, rBin_r, rGray_r;
  logic [AW:0]  wGs1_r, wGs2_r, rGs1_r, rGs2_r;
  logic [AW:0]  wBin_nxt, rBin_nxt;
  // Full and empty from the crossed gray pointers
  always_comb begin
    inReady  = (wGray_r != {~rGs2_r[AW:AW-1], rGs2_r[AW-2:0]});
    outValid = (rGray_r != wGs2_r);
    wBin_nxt = wBin_r + (AW+1)'(inValid && inReady);
    rBin_nxt = rBin_r + (AW+1)'(outValid && outReady);
    outData  = mem[rBin_r[AW-1:0]];
  end
  // Write side
  always_ff @(posedge wclk or negedge wrst_b) begin
    if (!wrst_b) begin
      wBin_r <= '0;
      wGray_r <= '0;
      rGs1_r <= '0;
      rGs2_r <= '0;
    end else begin
      wBin_r  <= wBin_nxt;
      wGray_r <= wBin_nxt ^ (wBin_nxt >> 1);
      rGs1_r  <= rGray_r;
      rGs2_r  <= rGs1_r;
    end
  end
  always_ff @(posedge wclk) begin
    if (inValid && inReady) begin
      mem[wBin_r[AW-1:0]] <= inData;
    end
  end
  // Read side
  always_ff @(posedge rclk or negedge rrst_b) begin
    if (!rrst_b) begin
      rBin_r <= '0;
      rGray_r <= '0;
      wGs1_r <= '0;
      wGs2_r <= '0;
    end else begin
      rBin_r  <= rBin_nxt;
      rGray_r <= rBin_nxt ^ (rBin_nxt >> 1);
      wGs1_r  <= wGray_r;
      wGs2_r  <= wGs1_r;
    end
  end
endmodule : sfcr_fifo
`default_nettype wire

// ---- src/sfcr_top.sv ----
// Continuous main-array read front end: serial link plus array fetch
`default_nettype none
module sfcr_top
  import sfcr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        sck,
  input  wire logic        csN,
  input  wire logic        si,
  output logic             so,
  output logic             soOe,
  input  wire logic        pageBin,
  output logic             fetchReq,
  output sfcr_addr_s       fetchAddr,
  input  wire logic        fetchAck,
  input  wire logic [7:0]  fetchData,
  output logic             busy
);
  typedef enum logic [3:0] {
    ST_OPC  = 4'b0001,
    ST_ADR  = 4'b0010,
    ST_DUM  = 4'b0100,
    ST_DAT  = 4'b1000
  } sfcr_st_e;

  // Link domain: reset whenever chip select is high, so each command restarts
  logic      linkRst_b;
  assign linkRst_b = rst_b & ~csN; // RQ12 RQ17

  sfcr_st_e   st_r, st_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [1:0] adrCnt_r, adrCnt_nxt;
  logic [2:0] dumCnt_r, dumCnt_nxt;
  logic [2:0] dumNeed_r, dumNeed_nxt;
  logic [23:0] adr_r, adr_nxt;
  logic [7:0] txByte_r, txByte_nxt;
  logic       startTgl_r, startTgl_nxt;
  logic [7:0] sampled;
  logic       firstPend_r, firstPend_nxt;
  // First data byte bypasses the FIFO: the FIFO's read side only sees new words
  // after two serial clocks, and none are left once the header is complete
  logic [7:0] headByte_r, headByte_nxt;
  logic       headDone_r, headDone_nxt;
  logic       fifoRst_b;
  logic       popReady;
  logic       fifoValid;
  logic [7:0] fifoData;

  assign sampled = {sh_r[6:0], si}; // RQ16

  // Command decode on the rising edge: opcode, address, dummy bytes
  always_comb begin
    st_nxt       = st_r;
    bit_nxt      = bit_r + 3'h1;
    sh_nxt       = sampled;
    adrCnt_nxt   = adrCnt_r;
    dumCnt_nxt   = dumCnt_r;
    dumNeed_nxt  = dumNeed_r;
    adr_nxt      = adr_r;
    startTgl_nxt = startTgl_r;
    popReady     = 1'b0;
    case (st_r)
      ST_OPC: begin
        if (bit_r == 3'h7) begin // RQ17
          st_nxt = ST_ADR;
          adrCnt_nxt = 2'h0;
          if (sampled == OP_LEGACY) dumNeed_nxt = DUMMY_LEGACY; // RQ1 RQ14
          else if (sampled == OP_FASTEST) dumNeed_nxt = DUMMY_FASTEST; // RQ2
          else if (sampled == OP_FAST) dumNeed_nxt = DUMMY_FAST; // RQ3
          else if (sampled == OP_SLOW) dumNeed_nxt = DUMMY_SLOW; // RQ4
          else st_nxt = ST_OPC; // Unknown opcode: stay silent until deselect
          if (!(sampled == OP_LEGACY || sampled == OP_FASTEST ||
                sampled == OP_FAST || sampled == OP_SLOW)) begin
            bit_nxt = 3'h7; // Park: never completes another opcode
            sh_nxt = 8'h00;
          end
        end
      end
      ST_ADR: begin
        if (bit_r == 3'h7) begin
          adr_nxt = {adr_r[15:0], sampled};
          adrCnt_nxt = adrCnt_r + 2'h1;
          if (adrCnt_r == 2'h2) begin
            if (dumNeed_r == 3'h0) begin
              st_nxt = ST_DAT; // RQ4
              startTgl_nxt = ~startTgl_r;
            end else begin
              st_nxt = ST_DUM;
              dumCnt_nxt = 3'h0;
            end
          end
        end
      end
      ST_DUM: begin
        // Dummy contents discarded
        if (bit_r == 3'h7) begin // RQ18
          dumCnt_nxt = dumCnt_r + 3'h1;
          if (dumCnt_r + 3'h1 == dumNeed_r) begin // RQ1 RQ2 RQ3
            st_nxt = ST_DAT;
            startTgl_nxt = ~startTgl_r;
          end
        end
      end
      ST_DAT: begin
        if (bit_r == 3'h7) popReady = 1'b1; // Next byte taken at byte end
      end
      default: st_nxt = ST_OPC;
    endcase
  end

  // Unknown opcodes park the state machine in opcode phase with bit 7 held
  logic parked_r, parked_nxt;
  always_comb begin
    parked_nxt = parked_r;
    if (st_r == ST_OPC && bit_r == 3'h7 && st_nxt == ST_OPC) parked_nxt = 1'b1;
  end

  // Rising-edge link registers; cleared while deselected
  always_ff @(posedge sck or negedge linkRst_b) begin
    if (!linkRst_b) begin
      st_r       <= ST_OPC;
      bit_r      <= BIT_RESET;
      sh_r       <= 8'h00;
      adrCnt_r   <= 2'h0;
      dumCnt_r   <= 3'h0;
      dumNeed_r  <= 3'h0;
      adr_r      <= 24'h000000;
      parked_r   <= 1'b0;
    end else if (!parked_r) begin
      st_r       <= st_nxt;
      bit_r      <= parked_nxt ? bit_r : bit_nxt;
      sh_r       <= sh_nxt;
      adrCnt_r   <= adrCnt_nxt;
      dumCnt_r   <= dumCnt_nxt;
      dumNeed_r  <= dumNeed_nxt;
      adr_r      <= adr_nxt;
      parked_r   <= parked_nxt;
    end
  end

  // Start toggle must survive deselect so the core sees every command
  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      startTgl_r <= 1'b0;
    end else begin
      startTgl_r <= startTgl_nxt;
    end
  end

  // Byte being shifted out; first byte from the head register, later ones from the FIFO
  always_comb begin
    txByte_nxt    = txByte_r;
    firstPend_nxt = (st_r != ST_DAT) && (st_nxt == ST_DAT);
    if (popReady) begin
      txByte_nxt = fifoValid ? fifoData : 8'h00;
    end else if (firstPend_r) begin
      txByte_nxt = {headByte_r[6:0], 1'b0}; // RQ8 RQ16
    end else if (st_r == ST_DAT) begin
      txByte_nxt = {txByte_r[6:0], 1'b0}; // RQ16
    end
  end
  always_ff @(posedge sck or negedge linkRst_b) begin
    if (!linkRst_b) begin
      txByte_r    <= 8'h00;
      firstPend_r <= 1'b0;
    end else begin
      txByte_r    <= txByte_nxt;
      firstPend_r <= firstPend_nxt;
    end
  end

  // Output changes on falling edge: works for idle-low and idle-high clocks
  always_ff @(negedge sck or negedge linkRst_b) begin
    if (!linkRst_b) begin
      so   <= 1'b0;
      soOe <= 1'b0; // RQ12
    end else begin
      // Head byte read across domains: the host must pause before data so it is settled
      so   <= firstPend_r ? headByte_r[7] : txByte_r[7]; // RQ8 RQ15
      soOe <= (st_r == ST_DAT);
    end
  end

  // Core domain: address counter and array fetch into the head register and the FIFO
  logic        startSync, startSeen_r, csHigh;
  logic        fillValid;
  logic        fillReady;
  logic [9:0]  offs_r, offs_nxt;
  logic [12:0] page_r, page_nxt;
  logic        fetchReq_r, fetchReq_nxt;
  logic [7:0]  fillData_r, fillData_nxt;
  logic        fillValid_r, fillValid_nxt;
  logic        startEdge;
  logic [9:0]  pageLast;

  sfcr_sync u_syncStart (
    .clk   (mclk),
    .rst_b (rst_b),
    .din   (startTgl_r),
    .dout  (startSync)
  );
  sfcr_sync u_syncCs (
    .clk   (mclk),
    .rst_b (rst_b),
    .din   (csN),
    .dout  (csHigh)
  );

  assign startEdge = startSync ^ startSeen_r;
  assign pageLast  = pageBin ? PAGE_LAST_BIN : PAGE_LAST_STD; // RQ19

  // Load start address, fetch, advance across pages and wrap the array
  always_comb begin
    offs_nxt      = offs_r;
    page_nxt      = page_r;
    fetchReq_nxt  = fetchReq_r;
    fillData_nxt  = fillData_r;
    fillValid_nxt = fillValid_r && !fillReady;
    headByte_nxt  = headByte_r;
    headDone_nxt  = headDone_r;
    if (startEdge) begin // RQ7
      headDone_nxt = 1'b0;
      if (pageBin) begin // RQ6
        page_nxt = adr_r[21:9];
        offs_nxt = {1'b0, adr_r[8:0]}; // RQ18
      end else begin // RQ5
        page_nxt = adr_r[22:10];
        offs_nxt = adr_r[9:0];
      end
      fetchReq_nxt = 1'b1;
    end else if (fetchReq_r && fetchAck && (!headDone_r || !fillValid_nxt)) begin
      if (headDone_r) begin
        fillData_nxt  = fetchData; // RQ13
        fillValid_nxt = 1'b1;
      end else begin
        headByte_nxt  = fetchData; // RQ13
        headDone_nxt  = 1'b1;
      end
      fetchReq_nxt  = !csHigh;
      if (offs_r == pageLast) begin // RQ10
        offs_nxt = 10'h000;
        page_nxt = (page_r == PAGE_LAST_IDX) ? 13'h0000 : page_r + 13'h0001; // RQ11
      end else begin
        offs_nxt = offs_r + 10'h001; // RQ7
      end
    end
    if (csHigh && !startEdge) fetchReq_nxt = 1'b0;
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      offs_r      <= 10'h000;
      page_r      <= 13'h0000;
      fetchReq_r  <= 1'b0;
      fillData_r  <= 8'h00;
      fillValid_r <= 1'b0;
      startSeen_r <= 1'b0;
      headByte_r  <= 8'h00;
      headDone_r  <= 1'b0;
    end else begin
      headByte_r  <= headByte_nxt;
      headDone_r  <= headDone_nxt;
      offs_r      <= offs_nxt;
      page_r      <= page_nxt;
      fetchReq_r  <= fetchReq_nxt;
      fillData_r  <= fillData_nxt;
      fillValid_r <= fillValid_nxt;
      startSeen_r <= startSync;
    end
  end

  assign fillValid = fillValid_r;
  assign fetchReq  = fetchReq_r && !fillValid_r;
  assign fetchAddr = '{page: page_r, offs: offs_r};
  assign busy      = fetchReq_r;

  // Both FIFO sides are cleared between commands so no stale prefetch leaks into
  // the next read; the write side follows the synchronised select
  assign fifoRst_b = rst_b & ~csHigh;

  // Prefetch buffer; its ready stalls array fetches
  sfcr_fifo #(.W(8), .D(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .wclk     (mclk),
    .wrst_b   (fifoRst_b),
    .inValid  (fillValid),
    .inReady  (fillReady),
    .inData   (fillData_r),
    .rclk     (sck),
    .rrst_b   (linkRst_b),
    .outValid (fifoValid),
    .outReady (popReady),
    .outData  (fifoData)
  );
endmodule : sfcr_top
`default_nettype wire

// ---- sim/sfcr_top_props.sv ----
// Checker: port-level properties of the continuous-read front end
`default_nettype none
module sfcr_top_props
  import sfcr_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic       csN,
  input wire logic       soOe,
  input wire logic       pageBin,
  input wire logic       fetchReq,
  input wire sfcr_addr_s fetchAddr,
  input wire logic       fetchAck
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sfcr_addr_s lastAddr_r;
  sfcr_addr_s lastNxt;
  logic       haveLast_r;
  // Successor of the last fetched byte, page and array wrap included
  always_comb begin
    lastNxt = lastAddr_r;
    if (lastAddr_r.offs == (pageBin ? PAGE_LAST_BIN : PAGE_LAST_STD)) begin
      lastNxt.offs = 10'h000;
      lastNxt.page = lastAddr_r.page + 13'h0001;
    end else begin
      lastNxt.offs = lastAddr_r.offs + 10'h001;
    end
  end
  // History is dropped while deselected: each command reloads the counter
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lastAddr_r <= '0;
      haveLast_r <= 1'b0;
    end else begin
      if (fetchReq && fetchAck) lastAddr_r <= fetchAddr;
      haveLast_r <= !csN && (haveLast_r || (fetchReq && fetchAck));
    end
  end
  sequence sTake;
    fetchReq && fetchAck;
  endsequence
  AST_OE_IDLE: assert property (csN |-> !soOe)
    else $error("so driven while deselected");
  AST_OE_START: assert property ($fell(csN) |-> !soOe)
    else $error("so driven at command start");
  AST_OE_HOLD: assert property (soOe && !csN |=> soOe || csN)
    else $error("so released mid read");
  AST_OE_LATE: assert property ($rose(soOe) |-> $past(csN, 40) == 1'b0)
    else $error("data before header complete");
  AST_ADDR_STD: assert property (fetchReq && !csN && !pageBin |-> fetchAddr.offs <= PAGE_LAST_STD)
    else $error("byte index past 528 page");
  AST_ADDR_BIN: assert property (fetchReq && !csN && pageBin |-> fetchAddr.offs <= PAGE_LAST_BIN)
    else $error("byte index past 512 page");
  AST_REQ_HOLD: assert property (fetchReq && !fetchAck && !csN |=> fetchReq && $stable(fetchAddr))
    else $error("fetch request dropped");
  AST_ADDR_NEXT: assert property (sTake ##0 haveLast_r |-> fetchAddr == lastNxt)
    else $error("fetch address not sequential");
endmodule : sfcr_top_props
bind sfcr_top sfcr_top_props u_sfcr_top_props (.mclk(mclk), .rst_b(rst_b), .csN(csN),
  .soOe(soOe), .pageBin(pageBin), .fetchReq(fetchReq), .fetchAddr(fetchAddr),
  .fetchAck(fetchAck));
`default_nettype wire

// ---- sim/sfcr_host.sv ----
// Host serial controller model: frames reads and captures data bytes
`default_nettype none
module sfcr_host (
  output logic       sck,
  output logic       csN,
  output logic       si,
  input  wire logic  so,
  input  wire logic  soOe,
  output logic [7:0] rxByte,
  output logic       rxTgl
);
  timeunit 1ns;
  timeprecision 1ns;
  logic inBit;
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    si = 1'b0;
    rxByte = 8'h00;
    rxTgl = 1'b0;
  end
  // One clock: drive on the fall, sample on the rise; silent so reads as unknown
  task automatic tick(input logic b);
    sck = 1'b0;
    si = b;
    #40;
    sck = 1'b1;
    inBit = soOe ? so : 1'bx;
    #40;
  endtask : tick
  // Clock stands still outside frames; long pause lets prefetch fill
  task automatic cmd(input logic [7:0] op, input logic [23:0] ad, input int nDum,
                     input int nRd, input logic md3);
    logic [7:0] b;
    sck = md3;
    #100;
    csN = 1'b0;
    #100;
    for (int i = 31; i >= 0; i--) tick(i > 23 ? op[i-24] : ad[i]);
    repeat (8 * nDum) tick(1'($urandom));
    #3000;
    for (int n = 0; n < nRd; n++) begin
      for (int k = 0; k < 8; k++) begin
        tick(1'b0);
        b = {b[6:0], inBit};
      end
      rxByte = b;
      rxTgl = ~rxTgl;
    end
    sck = md3;
    #40;
    csN = 1'b1;
    #200;
  endtask : cmd
endmodule : sfcr_host
`default_nettype wire

// ---- sim/sfcr_top_tb.sv ----
// Testbench: continuous reads over all opcodes, page sizes and wraps
`default_nettype none
module sfcr_top_tb;
  import sfcr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk, rst_b, sck, csN, si, so, soOe, pageBin, fetchReq, fetchAck, busy, rxTgl;
  logic [7:0] fetchData, rxByte;
  sfcr_addr_s fetchAddr;
  logic [7:0] expQ[$];
  logic [7:0] ops[4] = '{OP_LEGACY, OP_FASTEST, OP_FAST, OP_SLOW};
  int         dums[4] = '{4, 2, 1, 0};
  int         num_errors = 0;
  int         checks_done = 0;
  sfcr_top u_sfcr_top (.mclk(mclk), .rst_b(rst_b), .sck(sck), .csN(csN), .si(si), .so(so),
    .soOe(soOe), .pageBin(pageBin), .fetchReq(fetchReq), .fetchAddr(fetchAddr),
    .fetchAck(fetchAck), .fetchData(fetchData), .busy(busy));
  sfcr_host u_sfcr_host (.sck(sck), .csN(csN), .si(si), .so(so), .soOe(soOe),
    .rxByte(rxByte), .rxTgl(rxTgl));
  initial mclk = 1'b0;
  always #25 mclk = ~mclk;
  // Array contents: a cheap hash so neighbouring bytes differ
  function automatic logic [7:0] arr(input sfcr_addr_s a);
    return a.offs[7:0] ^ {a.page[5:0], a.offs[9:8]};
  endfunction : arr
  function automatic sfcr_addr_s nxt(input sfcr_addr_s a);
    nxt = a;
    if (a.offs == (pageBin ? PAGE_LAST_BIN : PAGE_LAST_STD)) begin
      nxt.offs = 10'h000;
      nxt.page = a.page + 13'h0001;
    end else nxt.offs = a.offs + 10'h001;
  endfunction : nxt
  // Array side: acks after a random stall, data valid with the ack
  always @(posedge mclk) begin
    fetchAck <= fetchReq && !fetchAck && ($urandom % 3 != 0);
    fetchData <= arr(fetchAddr);
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  // Each captured byte against the oldest note
  always @(rxTgl) if ($time > 0) check(rxByte, expQ.pop_front());
  // Negative dummy count marks a refused opcode: bus must stay silent
  task automatic run(input logic [7:0] op, input int nDum, input logic bin,
                     input logic [12:0] pg, input logic [9:0] of, input int n);
    sfcr_addr_s  a;
    logic [23:0] ad;
    @(posedge mclk);
    pageBin <= bin;
    repeat (4) @(posedge mclk);
    a = '{page: pg, offs: bin ? {1'b0, of[8:0]} : of};
    ad = bin ? {2'($urandom), pg, of[8:0]} : {1'($urandom), pg, of};
    for (int i = 0; i < n; i++) begin
      expQ.push_back(nDum < 0 ? 8'hXX : arr(a));
      a = nxt(a);
    end
    u_sfcr_host.cmd(op, ad, nDum, n, 1'($urandom));
    check(8'(soOe), 8'h00);
    repeat (2) @(posedge mclk);
    check(8'(busy), 8'h00);
    $display("test done: op %h, %0d bytes", op, n);
  endtask : run
  task automatic wrap_up();
    $display("%0d checks, %0d errors", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  initial begin
    void'($urandom(32'h5963));
    rst_b = 1'b0;
    pageBin = 1'b0;
    fetchAck = 1'b0;
    fetchData = 8'h00;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    // Every opcode with its own dummy count, random start, both page sizes
    for (int i = 0; i < 8; i++) begin
      run(ops[i%4], dums[i%4],
          i[2], 13'($urandom), 10'($urandom % 512), 3 + 2 * i);
    end
    run(OP_FAST, 1, 1'b0, 13'h0005, 10'h20E, 4);
    run(OP_SLOW, 0, 1'b1, 13'h0005, 10'h1FE, 4);
    run(OP_FASTEST, 2, 1'b0, 13'h1FFF, 10'h20D, 5);
    run(OP_LEGACY, 4, 1'b1, 13'h1FFF, 10'h1FF, 3);
    run(8'h5A, -1, 1'b0, 13'h0000, 10'h000, 2);
    wrap_up();
  end
  // Watchdog: several times the expected run length
  initial begin
    #1000000;
    num_errors++;
    wrap_up();
  end
endmodule : sfcr_top_tb
`default_nettype wire
